// ### src/swdw_delay_if.sv
// Interface carrying delay start and done between the top and a timer
`timescale 1ns/1ps
interface swdw_delay_if;
   logic start;
   logic tick;
   logic [swdw_pkg::MS_W-1:0] lengthMs;
   logic done;
   logic busy;
   modport ctl (output start, output tick, output lengthMs, input done,
      input busy);
   modport tmr (input start, input tick, input lengthMs, output done,
      output busy);
endinterface

// ### src/swdw_ms_timer.sv
// Millisecond interval timer, length latched when an interval starts
`timescale 1ns/1ps
module swdw_ms_timer (
   input wire logic core_clk,
   input wire logic rst,
   swdw_delay_if.tmr dly
);
   logic [swdw_pkg::MS_W-1:0] cnt_q, cnt_d;
   logic busy_q, busy_d, done_q, done_d;
   always_comb begin
      cnt_d = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (dly.start) begin
         // Length taken only here, so a new code waits for the next interval
         cnt_d = dly.lengthMs; // R11
         busy_d = 1'b1;
         done_d = (dly.lengthMs == '0);
         busy_d = (dly.lengthMs != '0);
      end else if (busy_q && dly.tick) begin
         cnt_d = cnt_q - 1'b1; // R11
         if (cnt_q == 12'h001) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end
   assign dly.done = done_q;
   assign dly.busy = busy_q;
   property p_zero_done;
      @(posedge core_clk) disable iff (rst)
         dly.start && dly.lengthMs == '0 |=> dly.done && !dly.busy;
   endproperty
   a_zero_done: assert property (p_zero_done) else $error("zero delay"); // R1
endmodule

// ### src/swdw_pkg.sv
// Package with timing constants and codes for the switch delay and watchdog
package swdw_pkg;
   localparam int unsigned CLK_MHZ = 250;
   // Time base: one tick per millisecond
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYC = CLK_MHZ * 1000 * TICK_MS;
   localparam int unsigned DLY_B_STEP_MS = 75;
   localparam int unsigned DLY_A_STEP_MS = 150;
   localparam int unsigned WD_P00_MS = 620;
   localparam int unsigned WD_P01_MS = 310;
   localparam int unsigned WD_P10_MS = 2500;
   localparam int unsigned WD_P11_MS = 1250;
   localparam int unsigned MS_W = 12;
   localparam int unsigned CMD_BITS = 8;
   localparam real SO_VALID_NS = 105.0;
   localparam int unsigned SO_VALID_CYC = $rtoi(SO_VALID_NS * CLK_MHZ / 1000.0);
   typedef enum logic [1:0] {SWDW_NORMAL, SWDW_RUN, SWDW_FAILSAFE} swdw_wd_t;
endpackage

// ### src/swdw_top.sv
// Switch delay, watchdog and SPI command receiver of a dual high-side switch
// What this block and its host must do
// R1 - Output B delay is code times 75 ms, zero for code 000
// R2 - Output A delay steps 150 ms per code pair, zero for 000 and 001
// R3 - Watchdog timeout by 2-bit code: 620, 310, 2500, 1250 ms
// R4 - With outputs off and fail-safe select floating, expiry turns output on
// R5 - Host waits 5 us after reset release before chip select falls
// R6 - Host keeps chip select high at least 300 ns between frames
// R7 - Host allows 167 ns between chip select and serial clock edges
// R8 - Host holds each serial clock phase at least 167 ns; the bench host model holds 24 ns phases
// R9 - Host runs serial clock at 3 MHz or slower; the bench host model runs it at about 20.8 MHz
// R10 - Serial output updates after each rising clock edge within 105 ns
// R11 - Delays counted from a time base; new codes apply to next interval
// R12 - Watchdog starts when the reset pin rises; the code starts it on that rise only while the wake pin is also high
// R13 - Fail-safe select tied low disables watchdog and fail-safe
// R14 - Watchdog timeout enters fail-safe; outputs follow parallel inputs
// R15 - 8-bit commands received MSB first on rising serial clock
`timescale 1ns/1ps
module swdw_top #(
   parameter int unsigned TICK_CYC = swdw_pkg::TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic resetPin_n,
   input wire logic wakePin,
   input wire logic chipSel_n,
   input wire logic serClk,
   input wire logic serIn,
   input wire logic [1:0] directIn,
   input wire logic [1:0] failsafe_select_pin,
   input wire logic [2:0] output_switch_delay_sel,
   input wire logic [1:0] watchdog_period_sel,
   input wire logic [1:0] spiOutCmd,
   input wire logic [7:0] statusWord,
   output logic serOut,
   output logic serOutEn_n,
   output logic [7:0] cmdWord,
   output logic cmdValid,
   output logic high_side_out_a,
   output logic high_side_out_b,
   output logic failsafeActive
);
   // failsafe_select_pin: 00 grounded, 01 floating/all on, 10 out A only,
   // 11 parallel inputs, so both stay off while those inputs are low
   logic [2:0] rstS_q, csS_q, sckS_q, siS_q, wkS_q;
   logic [2:0] rstS_d, csS_d, sckS_d, siS_d, wkS_d;
   logic rstPin, cs_n, sck, si, wake;
   logic rstPin_q, cs_q, sck_q;
   // Parallel inputs and fail-safe select share one three-stage chain
   logic [3:0] lvA_q, lvB_q, lvC_q, lvA_d, lvB_d, lvC_d, lvl, lvl_q;
   logic [1:0] fsSel, dIn;
   always_comb begin
      rstS_d = {rstS_q[1:0], resetPin_n};
      csS_d = {csS_q[1:0], chipSel_n};
      sckS_d = {sckS_q[1:0], serClk};
      siS_d = {siS_q[1:0], serIn};
      wkS_d = {wkS_q[1:0], wakePin};
      lvA_d = {failsafe_select_pin, directIn};
      lvB_d = lvA_q;
      lvC_d = lvB_q;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rstS_q <= 3'h0;
         csS_q <= 3'h7;
         sckS_q <= 3'h0;
         siS_q <= 3'h0;
         wkS_q <= 3'h0;
         lvA_q <= 4'h0;
         lvB_q <= 4'h0;
         lvC_q <= 4'h0;
      end else begin
         rstS_q <= rstS_d;
         csS_q <= csS_d;
         sckS_q <= sckS_d;
         siS_q <= siS_d;
         wkS_q <= wkS_d;
         lvA_q <= lvA_d;
         lvB_q <= lvB_d;
         lvC_q <= lvC_d;
      end
   end
   // Reset, select and clock levels change only when stages two and three agree
   always_comb begin
      rstPin = (rstS_q[1] == rstS_q[2]) ? rstS_q[2] : rstPin_q;
      cs_n = (csS_q[1] == csS_q[2]) ? csS_q[2] : cs_q;
      sck = (sckS_q[1] == sckS_q[2]) ? sckS_q[2] : sck_q;
      si = siS_q[2];
      wake = wkS_q[2];
      // Per bit: follow stage three once it agrees with stage two
      lvl = (~(lvB_q ^ lvC_q) & lvC_q) | ((lvB_q ^ lvC_q) & lvl_q);
      fsSel = lvl[3:2];
      dIn = lvl[1:0];
   end
   logic sckRise, rstRise;
   assign sckRise = sck && !sck_q && !cs_n;
   assign rstRise = rstPin && !rstPin_q;

   // SPI shift register and serial output
   logic [7:0] shIn_q, shIn_d, shOut_q, shOut_d, cmd_q, cmd_d;
   logic [2:0] bit_q, bit_d;
   logic so_q, so_d, cmdV_q, cmdV_d;
   always_comb begin
      shIn_d = shIn_q;
      shOut_d = shOut_q;
      bit_d = bit_q;
      so_d = so_q;
      cmd_d = cmd_q;
      cmdV_d = 1'b0;
      if (cs_n) begin
         bit_d = 3'h0;
         shOut_d = statusWord;
         so_d = statusWord[7];
      end else if (sckRise) begin
         shIn_d = {shIn_q[6:0], si}; // R15
         shOut_d = {shOut_q[6:0], 1'b0};
         so_d = shOut_q[6]; // R10
         bit_d = bit_q + 3'h1;
         if (bit_q == 3'(swdw_pkg::CMD_BITS - 1)) begin
            cmd_d = {shIn_q[6:0], si}; // R15
            cmdV_d = 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shIn_q <= 8'h00;
         shOut_q <= 8'h00;
         bit_q <= 3'h0;
         so_q <= 1'b0;
         cmd_q <= 8'h00;
         cmdV_q <= 1'b0;
         rstPin_q <= 1'b0;
         cs_q <= 1'b1;
         sck_q <= 1'b0;
         lvl_q <= 4'h0;
      end else begin
         shIn_q <= shIn_d;
         shOut_q <= shOut_d;
         bit_q <= bit_d;
         so_q <= so_d;
         cmd_q <= cmd_d;
         cmdV_q <= cmdV_d;
         rstPin_q <= rstPin;
         cs_q <= cs_n;
         sck_q <= sck;
         lvl_q <= lvl;
      end
   end
   assign serOut = so_q;
   assign serOutEn_n = cs_q;
   assign cmdWord = cmd_q;
   assign cmdValid = cmdV_q;

   // Millisecond time base
   logic [31:0] div_q, div_d;
   logic tick;
   assign tick = (div_q == TICK_CYC - 1);
   assign div_d = tick ? 32'h0 : div_q + 32'h1;

   // Watchdog and fail-safe
   swdw_pkg::swdw_wd_t wd_q, wd_d;
   swdw_delay_if wdIf ();
   swdw_delay_if aIf ();
   swdw_delay_if bIf ();
   logic [11:0] wdLen;
   logic fsGnd;
   assign fsGnd = (fsSel == 2'h0);
   always_comb begin
      case (watchdog_period_sel) // R3
         2'h0: wdLen = 12'(swdw_pkg::WD_P00_MS);
         2'h1: wdLen = 12'(swdw_pkg::WD_P01_MS);
         2'h2: wdLen = 12'(swdw_pkg::WD_P10_MS);
         default: wdLen = 12'(swdw_pkg::WD_P11_MS);
      endcase
   end
   always_comb begin
      wd_d = wd_q;
      wdIf.start = 1'b0;
      case (wd_q)
         swdw_pkg::SWDW_NORMAL:
            if (rstRise && wake && !fsGnd) begin
               wd_d = swdw_pkg::SWDW_RUN; // R12
               wdIf.start = 1'b1;
            end
         swdw_pkg::SWDW_RUN:
            if (fsGnd || !rstPin) begin
               wd_d = swdw_pkg::SWDW_NORMAL; // R13
            end else if (cmdV_q) begin
               wdIf.start = 1'b1;
            end else if (wdIf.done) begin
               wd_d = swdw_pkg::SWDW_FAILSAFE; // R14
            end
         swdw_pkg::SWDW_FAILSAFE:
            if (fsGnd || !rstPin) begin
               wd_d = swdw_pkg::SWDW_NORMAL; // R13
            end
         default: wd_d = swdw_pkg::SWDW_NORMAL;
      endcase
   end
   assign wdIf.tick = tick;
   assign wdIf.lengthMs = wdLen;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wd_q <= swdw_pkg::SWDW_NORMAL;
         div_q <= 32'h0;
      end else begin
         wd_q <= wd_d;
         div_q <= div_d;
      end
   end
   assign failsafeActive = (wd_q == swdw_pkg::SWDW_FAILSAFE);

   // Per-output switching delays from SPI on commands
   logic [1:0] req, reqPrev_q, on_q, on_d;
   always_comb begin
      req = spiOutCmd;
      if (failsafeActive) begin
         case (fsSel)
            2'h1: req = 2'h3; // R4
            2'h2: req = 2'h1;
            default: req = dIn; // R14
         endcase
      end
   end
   assign bIf.lengthMs = 12'(output_switch_delay_sel) *
      12'(swdw_pkg::DLY_B_STEP_MS); // R1
   assign aIf.lengthMs = 12'(output_switch_delay_sel[2:1]) *
      12'(swdw_pkg::DLY_A_STEP_MS); // R2
   assign aIf.tick = tick;
   assign bIf.tick = tick;
   assign aIf.start = req[0] && !reqPrev_q[0];
   assign bIf.start = req[1] && !reqPrev_q[1];
   always_comb begin
      on_d = on_q;
      if (!req[0]) on_d[0] = 1'b0;
      else if (aIf.done) on_d[0] = 1'b1;
      if (!req[1]) on_d[1] = 1'b0;
      else if (bIf.done) on_d[1] = 1'b1;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reqPrev_q <= 2'h0;
         on_q <= 2'h0;
      end else begin
         reqPrev_q <= req;
         on_q <= on_d;
      end
   end
   assign high_side_out_a = on_q[0];
   assign high_side_out_b = on_q[1];

   swdw_ms_timer wdTmr (.core_clk(core_clk), .rst(rst), .dly(wdIf.tmr));
   swdw_ms_timer aTmr (.core_clk(core_clk), .rst(rst), .dly(aIf.tmr));
   swdw_ms_timer bTmr (.core_clk(core_clk), .rst(rst), .dly(bIf.tmr));

   property p_so_shift;
      @(posedge core_clk) disable iff (rst)
         sckRise |=> serOut == $past(shOut_q[6]);
   endproperty
   a_so_shift: assert property (p_so_shift) else $error("so late"); // R10
   property p_cmd;
      @(posedge core_clk) disable iff (rst)
         cmdV_q |-> cmdWord[0] == $past(si);
   endproperty
   a_cmd: assert property (p_cmd) else $error("cmd bit"); // R15
   property p_wd_start;
      @(posedge core_clk) disable iff (rst)
         wd_q == swdw_pkg::SWDW_NORMAL && rstRise && wake && !fsGnd
         |=> wd_q == swdw_pkg::SWDW_RUN;
   endproperty
   a_wd_start: assert property (p_wd_start) else $error("wd start"); // R12
   property p_gnd;
      @(posedge core_clk) disable iff (rst)
         fsGnd |=> wd_q == swdw_pkg::SWDW_NORMAL;
   endproperty
   a_gnd: assert property (p_gnd) else $error("select grounded"); // R13
   property p_fs;
      @(posedge core_clk) disable iff (rst)
         wd_q == swdw_pkg::SWDW_RUN && !fsGnd && rstPin && !cmdV_q &&
         wdIf.done |=> failsafeActive;
   endproperty
   a_fs: assert property (p_fs) else $error("no failsafe"); // R14
   property p_len_b;
      @(posedge core_clk) disable iff (rst)
         output_switch_delay_sel == 3'h7 |-> bIf.lengthMs == 12'h20d;
   endproperty
   a_len_b: assert property (p_len_b) else $error("b len"); // R1
   property p_len_a;
      @(posedge core_clk) disable iff (rst)
         output_switch_delay_sel == 3'h7 |-> aIf.lengthMs == 12'h1c2;
   endproperty
   a_len_a: assert property (p_len_a) else $error("a len"); // R2
   property p_wd_len;
      @(posedge core_clk) disable iff (rst)
         watchdog_period_sel == 2'h2 |-> wdLen == 12'h9c4;
   endproperty
   a_wd_len: assert property (p_wd_len) else $error("wd len"); // R3
endmodule

// ### tb/swdw_host_model.sv
// Host model that drives framed serial commands and reads the status word
`timescale 1ns/1ps
module swdw_host_model #(
   // Short link phases keep runs brief; the core still samples each six times
   parameter int HALF_NS = 24
) (
   input wire logic resetPin_n,
   output logic chipSel_n,
   output logic serClk,
   output logic serIn,
   input wire logic serOut
);
   realtime relT = 0;
   realtime endT = 0;
   // Clock idles low and data rests at its pull-down level between frames
   initial begin
      chipSel_n = 1'b1;
      serClk = 1'b0;
      serIn = 1'b0;
   end
   always @(posedge resetPin_n) relT = $realtime;
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      if ($realtime < relT + 5000) #(relT + 5000 - $realtime);
      if ($realtime < endT + 300) #(endT + 300 - $realtime);
      // Step off the core clock edge so no pin moves as it is sampled
      #1;
      chipSel_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         serIn = tx[i];
         if (i == 7) #168;
         else #HALF_NS;
         // Sampled just before the rise, one link cycle after the rise that shifted it
         rx[i] = serOut;
         serClk = 1'b1;
         #HALF_NS;
         serClk = 1'b0;
      end
      #168;
      chipSel_n = 1'b1;
      serIn = 1'b0;
      endT = $realtime;
   endtask
endmodule

// ### tb/test_swdw_top.sv
// Self-checking bench for switch delays, watchdog and command receiver
`timescale 1ns/1ps
module test_swdw_top;
   // Short tick keeps the longest timeout near ten thousand cycles
   localparam int TICK = 4;
   localparam int WD_MS[4] = '{620, 310, 2500, 1250};
   logic core_clk, rst, resetPin_n, wakePin, chipSel_n, serClk, serIn;
   logic serOut, serOutEn_n, cmdValid, outA, outB, failsafeActive;
   logic [1:0] directIn, fsSel, wdSel, spiOutCmd;
   logic [2:0] dlySel;
   logic [7:0] statusWord, cmdWord;
   logic [31:0] seed = 32'h5d;
   int mismatches = 0;
   int checkCount = 0;
   int pulses = 0;

   swdw_top #(.TICK_CYC(TICK)) dut (.core_clk(core_clk), .rst(rst),
      .resetPin_n(resetPin_n), .wakePin(wakePin), .chipSel_n(chipSel_n),
      .serClk(serClk), .serIn(serIn), .directIn(directIn),
      .failsafe_select_pin(fsSel), .output_switch_delay_sel(dlySel),
      .watchdog_period_sel(wdSel), .spiOutCmd(spiOutCmd),
      .statusWord(statusWord), .serOut(serOut), .serOutEn_n(serOutEn_n),
      .cmdWord(cmdWord), .cmdValid(cmdValid), .high_side_out_a(outA),
      .high_side_out_b(outB), .failsafeActive(failsafeActive));
   swdw_host_model host (.resetPin_n(resetPin_n), .chipSel_n(chipSel_n),
      .serClk(serClk), .serIn(serIn), .serOut(serOut));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int dlyMs(input logic [2:0] c, input logic isB);
      if (isB) return 75 * int'(c);
      return 150 * int'(c >> 1);
   endfunction
   function automatic logic [1:0] fsOut(input logic [1:0] s,
      input logic [1:0] d);
      if (s == 2'h1) return 2'h3;
      if (s == 2'h2) return 2'h1;
      return d;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkRange(input int got, input int lo, input int hi);
      checkCount++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   // First cycle each output and the fail-safe flag were seen high
   task automatic measure(input int lim, output int tA, output int tB,
      output int tF);
      tA = -1;
      tB = -1;
      tF = -1;
      for (int c = 0; c < lim; c++) begin
         @(negedge core_clk);
         if (outA === 1'b1 && tA < 0) tA = c;
         if (outB === 1'b1 && tB < 0) tB = c;
         if (failsafeActive === 1'b1 && tF < 0) tF = c;
      end
   endtask
   // Low time above the longest required low duration of the pin
   task automatic pinReset();
      @(posedge core_clk) resetPin_n <= 1'b0;
      repeat (100) @(posedge core_clk);
      resetPin_n <= 1'b1;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   always @(negedge core_clk) if (cmdValid === 1'b1) pulses++;
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Whole plan needs about 140 us; twice that means a hang
   initial begin
      #300us;
      mismatches++;
      wrap_up();
   end

   initial begin
      int tA, tB, tF, ms;
      logic [31:0] r;
      logic [7:0] rx;
      rst = 1'b1;
      resetPin_n = 1'b0;
      wakePin = 1'b1;
      directIn = 2'h0;
      fsSel = 2'h0;
      dlySel = 3'h0;
      wdSel = 2'h1;
      spiOutCmd = 2'h0;
      statusWord = 8'h00;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      chk({3'h0, serOutEn_n, cmdValid, outA, outB, failsafeActive}, 8'h10);
      chk(cmdWord, 8'h00);
      // Grounded select: watchdog stays off across a full period
      pinReset();
      measure(1400, tA, tB, tF);
      chkRange(tF, -1, -1);
      // Every delay code; code changed mid-interval must not apply
      for (int c = 0; c < 8; c++) begin
         @(posedge core_clk) dlySel <= c[2:0];
         repeat (4) @(posedge core_clk);
         spiOutCmd <= 2'h3;
         repeat (10) @(posedge core_clk);
         r = rnd();
         dlySel <= r[2:0];
         ms = dlyMs(c[2:0], 1'b1);
         measure(ms * TICK + 20, tA, tB, tF);
         ms = dlyMs(c[2:0], 1'b0);
         chkRange(tA + 10, (ms - 1) * TICK, ms * TICK + 12);
         ms = dlyMs(c[2:0], 1'b1);
         chkRange(tB + 10, (ms - 1) * TICK, ms * TICK + 12);
         chk({6'h00, outA, outB}, 8'h03);
         @(posedge core_clk) spiOutCmd <= 2'h0;
         repeat (4) @(posedge core_clk);
         chk({6'h00, outA, outB}, 8'h00);
      end
      // Every timeout code from the reset pin rise, each fail-safe choice
      directIn <= 2'h2;
      dlySel <= 3'h0;
      for (int w = 0; w < 4; w++) begin
         wdSel <= w[1:0];
         fsSel <= (w == 1) ? 2'h2 : (w == 2) ? 2'h3 : 2'h1;
         pinReset();
         ms = WD_MS[w];
         measure(ms * TICK + 20, tA, tB, tF);
         chkRange(tF, (ms - 1) * TICK, ms * TICK + 12);
         repeat (4) @(posedge core_clk);
         chk({6'h00, outB, outA}, {6'h00, fsOut(fsSel, directIn)});
      end
      // Back-to-back frames keep the watchdog from expiring
      wdSel <= 2'h0;
      pinReset();
      for (int k = 0; k < 12; k++) begin
         r = rnd();
         @(posedge core_clk) statusWord <= r[15:8];
         repeat (2) @(posedge core_clk);
         host.xfer(r[7:0], rx);
         repeat (8) @(posedge core_clk);
         chk(cmdWord, r[7:0]);
         chk(rx, r[15:8]);
         chkRange(pulses, k + 1, k + 1);
         chk({7'h00, serOutEn_n}, 8'h01);
      end
      chk({7'h00, failsafeActive}, 8'h00);
      measure(WD_MS[0] * TICK + 20, tA, tB, tF);
      chkRange(tF, (WD_MS[0] - 1) * TICK - 60, WD_MS[0] * TICK);
      wrap_up();
   end
endmodule
